/* File: logic/seconds_counter_pkg.sv */
// Shared constants for the serial seconds counter
package seconds_counter_pkg;
	// Command byte layout
	localparam int CMD_W         = 8;
	localparam int SEL_CONT_BIT  = 7;
	localparam int SEL_POW_BIT   = 6;
	localparam int TRIM_HI_BIT   = 5;
	localparam int TRIM_LO_BIT   = 3;
	localparam int CLR_CONT_BIT  = 2;
	localparam int CLR_POW_BIT   = 1;
	localparam int READ_BIT      = 0;
	// Counter and trim geometry
	localparam int CNT_W         = 32;
	localparam int TRIM_W        = 3;
	localparam logic [2:0] TRIM_RESET = 3'h3;
	localparam logic [2:0] TRIM_STOP  = 3'h0;
	// Serial bit counting
	localparam int BIT_CNT_W     = 5;
	localparam logic [4:0] CMD_LAST_IDX  = 5'h07;
	localparam logic [4:0] DATA_LAST_IDX = 5'h1F;
	localparam logic [4:0] BIT_STEP      = 5'h01;
	// Link phases, Gray order along the usual path
	typedef enum logic [1:0] {
		PH_CMD  = 2'h0,
		PH_DATA = 2'h1,
		PH_DONE = 2'h3
	} phase_e;
endpackage

/* File: logic/serial_elapsed_seconds_counter.sv */
// Dual seconds counter with three-wire serial access port
// Functional notes
// R01: Command bits 7..0: cont select, powered select, trim[2:0], cont clear, powered clear, read.
// R02: Cont select only with read: shift out continuous counter over 32 clocks, change nothing.
// R03: Cont select only with write: take 32 bits into continuous counter, no trim or clear.
// R04: Powered select only with read: shift out powered counter over 32 clocks, change nothing.
// R05: Powered select only: the 32 following clocks access powered counter, write when read is 0.
// R06: No select and cont clear: continuous counter goes to zero at command end.
// R07: No select and powered clear: powered counter goes to zero at command end.
// R08: Both selects with write: load trim bits, counters untouched.
// R09: While main supply is low, all serial reads and writes are refused.
// R10: Host holds port enable high for the whole transfer.
// R11: One bidirectional data line carries command, write data and read data.
// R12: All bit movement is timed by the host serial clock.
// R13: Command and write bits are sampled on the serial clock rising edge.
// R14: Read bits are driven starting at a serial clock falling edge.
// R15: Read data is a snapshot taken at command end, shifted out unchanged.
// R16: After 32 data bits, clocks are ignored; data line released unless reading (the code releases it after a read too).
// R17: Written bits are buffered and loaded into the counter all at once.
`timescale 1ns/1ps

module serial_elapsed_seconds_counter #(
	parameter int CNT_W = seconds_counter_pkg::CNT_W
) (
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic             ser_clk,
	input  wire logic             port_en,
	input  wire logic             dq_in,
	output logic                  dq_out,
	output logic                  dq_oe,
	input  wire logic             osc_tick,
	input  wire logic             supply_low,
	output logic [2:0]            trim_value,
	output logic [CNT_W-1:0]      continuous_count,
	output logic [CNT_W-1:0]      powered_count
);

	// Exactly one counter selected means a 32-bit data phase follows
	function automatic logic counter_access(input logic [7:0] cmd);
		counter_access = cmd[seconds_counter_pkg::SEL_CONT_BIT] ^ cmd[seconds_counter_pkg::SEL_POW_BIT];
	endfunction

	// Seconds increment shared by both counters
	function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
		bump = v + {{(CNT_W-1){1'b0}}, 1'b1};
	endfunction

	// Link domain state
	seconds_counter_pkg::phase_e phase_reg;
	seconds_counter_pkg::phase_e phase_next;
	logic [4:0]       bit_cnt_reg;
	logic [4:0]       bit_cnt_next;
	logic [7:0]       cmd_reg;
	logic [7:0]       cmd_shift_next;
	logic [CNT_W-1:0] data_reg;
	logic [CNT_W-1:0] data_next;
	logic [CNT_W-1:0] snap_pick;
	logic             cmd_done_reg;
	logic             write_done_reg;
	logic             frame_seq_reg;
	logic             dq_out_reg;
	logic             dq_oe_reg;

	// System domain state
	logic             en_s1_reg;
	logic             en_s2_reg;
	logic             en_s3_reg;
	logic             tick_s1_reg;
	logic             tick_s2_reg;
	logic             tick_s3_reg;
	logic             low_s1_reg;
	logic             low_s2_reg;
	logic             blocked_reg;
	logic             seen_seq_reg;
	logic [CNT_W-1:0] shadow_cont_reg;
	logic [CNT_W-1:0] shadow_pow_reg;
	logic [CNT_W-1:0] cont_reg;
	logic [CNT_W-1:0] cont_next;
	logic [CNT_W-1:0] pow_reg;
	logic [CNT_W-1:0] pow_next;
	logic [2:0]       trim_reg;
	logic [2:0]       trim_next;

	// Port enable low ends any frame at once, without a clock
	wire link_clr = ~port_en | sys_rst; // R10

	// Link phase decode
	wire in_cmd    = (phase_reg == seconds_counter_pkg::PH_CMD);
	wire in_data   = (phase_reg == seconds_counter_pkg::PH_DATA);
	wire in_done   = (phase_reg == seconds_counter_pkg::PH_DONE);
	wire cmd_last  = in_cmd && (bit_cnt_reg == seconds_counter_pkg::CMD_LAST_IDX);
	wire data_last = in_data && (bit_cnt_reg == seconds_counter_pkg::DATA_LAST_IDX);
	wire frame_first = in_cmd && (bit_cnt_reg == '0);
	wire cmd_read  = cmd_reg[seconds_counter_pkg::READ_BIT];
	wire nxt_read  = cmd_shift_next[seconds_counter_pkg::READ_BIT];

	// Command bits arrive MSB first
	assign cmd_shift_next = {cmd_reg[6:0], dq_in}; // R13

	// Trim and clear commands end the frame; further clocks ignored
	assign phase_next = cmd_last ? (counter_access(cmd_shift_next) ? seconds_counter_pkg::PH_DATA
	                                                               : seconds_counter_pkg::PH_DONE)
	                  : data_last ? seconds_counter_pkg::PH_DONE : phase_reg; // R16
	assign bit_cnt_next = (cmd_last || data_last) ? '0
	                    : in_done ? bit_cnt_reg : bit_cnt_reg + seconds_counter_pkg::BIT_STEP;

	// Snapshot source picked from the byte being completed
	assign snap_pick = cmd_shift_next[seconds_counter_pkg::SEL_CONT_BIT] ? shadow_cont_reg
	                                                                     : shadow_pow_reg; // R15

	// One register serves read snapshot and write buffer, LSB first
	assign data_next = (cmd_last && nxt_read) ? snap_pick
	                 : in_data ? {dq_in, data_reg[CNT_W-1:1]} : data_reg; // R17

	// Frame position; cleared by port enable
	always_ff @(posedge ser_clk or posedge link_clr) begin // R12
		if (link_clr) begin
			phase_reg   <= seconds_counter_pkg::PH_CMD;
			bit_cnt_reg <= '0;
		end else begin
			phase_reg   <= phase_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	// Command and data survive the frame end for the system side
	always_ff @(posedge ser_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_reg  <= '0;
			data_reg <= '0;
		end else begin
			cmd_reg  <= in_cmd ? cmd_shift_next : cmd_reg; // R13
			data_reg <= data_next; // R03
		end
	end

	// Completion flags, plus a sequence bit so empty frames repeat nothing
	always_ff @(posedge ser_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_done_reg   <= 1'b0;
			write_done_reg <= 1'b0;
			frame_seq_reg  <= 1'b0;
		end else begin
			cmd_done_reg   <= cmd_last | (cmd_done_reg & ~frame_first);
			write_done_reg <= (data_last & ~cmd_read) | (write_done_reg & ~frame_first); // R17
			frame_seq_reg  <= frame_seq_reg ^ frame_first;
		end
	end

	// Read bits launched on the falling edge; released when the frame ends
	always_ff @(negedge ser_clk or posedge link_clr) begin // R14
		if (link_clr) begin
			dq_oe_reg  <= 1'b0;
			dq_out_reg <= 1'b0;
		end else begin
			dq_oe_reg  <= in_data & cmd_read & ~blocked_reg; // R16
			dq_out_reg <= data_reg[0]; // R11
		end
	end

	assign dq_out = dq_out_reg; // R11
	assign dq_oe  = dq_oe_reg;

	// Two-stage synchronisers; third stage for edge detection, and on port enable also for the idle check
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en_s1_reg   <= 1'b0;
			en_s2_reg   <= 1'b0;
			en_s3_reg   <= 1'b0;
			tick_s1_reg <= 1'b0;
			tick_s2_reg <= 1'b0;
			tick_s3_reg <= 1'b0;
			low_s1_reg  <= 1'b0;
			low_s2_reg  <= 1'b0;
		end else begin
			en_s1_reg   <= port_en;
			en_s2_reg   <= en_s1_reg;
			en_s3_reg   <= en_s2_reg;
			tick_s1_reg <= osc_tick;
			tick_s2_reg <= tick_s1_reg;
			tick_s3_reg <= tick_s2_reg;
			low_s1_reg  <= supply_low;
			low_s2_reg  <= low_s1_reg;
		end
	end

	// Frame boundaries seen from the system clock
	wire port_idle = ~en_s2_reg & ~en_s3_reg;
	wire frame_end = en_s3_reg & ~en_s2_reg;
	wire fresh     = frame_seq_reg ^ seen_seq_reg;
	wire go        = frame_end & fresh & ~blocked_reg; // R09

	// Link registers are quiet once the frame ends, so direct reads are safe
	wire sel_c     = cmd_reg[seconds_counter_pkg::SEL_CONT_BIT];
	wire sel_p     = cmd_reg[seconds_counter_pkg::SEL_POW_BIT];
	wire wr_any    = go & write_done_reg & counter_access(cmd_reg) & ~cmd_read;
	wire wr_cont   = wr_any & sel_c; // R03
	wire wr_pow    = wr_any & sel_p; // R05
	wire clr_any   = go & cmd_done_reg & ~sel_c & ~sel_p;
	wire clr_cont  = clr_any & cmd_reg[seconds_counter_pkg::CLR_CONT_BIT]; // R06
	wire clr_pow   = clr_any & cmd_reg[seconds_counter_pkg::CLR_POW_BIT]; // R07
	wire trim_load = go & cmd_done_reg & sel_c & sel_p & ~cmd_read; // R08
	wire [2:0] cmd_trim = cmd_reg[seconds_counter_pkg::TRIM_HI_BIT:seconds_counter_pkg::TRIM_LO_BIT]; // R01

	// Trim zero stops the oscillator, so no seconds arrive
	wire run       = (trim_reg != seconds_counter_pkg::TRIM_STOP);
	wire sec_tick  = tick_s2_reg & ~tick_s3_reg & run;

	// Port writes win over a coincident tick
	assign cont_next = wr_cont ? data_reg : clr_cont ? '0 : sec_tick ? bump(cont_reg) : cont_reg;
	assign pow_next  = wr_pow ? data_reg : clr_pow ? '0
	                 : (sec_tick & ~low_s2_reg) ? bump(pow_reg) : pow_reg;
	assign trim_next = trim_load ? cmd_trim : trim_reg;

	// Counters and trim
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cont_reg <= '0;
			pow_reg  <= '0;
			trim_reg <= seconds_counter_pkg::TRIM_RESET;
		end else begin
			cont_reg <= cont_next;
			pow_reg  <= pow_next;
			trim_reg <= trim_next;
		end
	end

	// Shadows and access gate freeze while a frame may be open
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			shadow_cont_reg <= '0;
			shadow_pow_reg  <= '0;
			blocked_reg     <= 1'b1;
			seen_seq_reg    <= 1'b0;
		end else begin
			shadow_cont_reg <= port_idle ? cont_reg : shadow_cont_reg;
			shadow_pow_reg  <= port_idle ? pow_reg : shadow_pow_reg;
			blocked_reg     <= port_idle ? low_s2_reg : blocked_reg; // R09
			seen_seq_reg    <= frame_end ? frame_seq_reg : seen_seq_reg;
		end
	end

	assign trim_value       = trim_reg;
	assign continuous_count = cont_reg;
	assign powered_count    = pow_reg;

	// Checks on the system side
	sequence s_go;
		go;
	endsequence

	property p_clear_cont;
		@(posedge clk_sys) disable iff (sys_rst) s_go ##0 clr_cont |=> cont_reg == '0;
	endproperty
	a_clear_cont: assert property (p_clear_cont) else $error("continuous clear missed"); // R06

	property p_clear_pow;
		@(posedge clk_sys) disable iff (sys_rst) s_go ##0 clr_pow |=> pow_reg == '0;
	endproperty
	a_clear_pow: assert property (p_clear_pow) else $error("powered clear missed"); // R07

	property p_trim;
		// A tick in the same cycle may still advance the count; the command itself must not
		@(posedge clk_sys) disable iff (sys_rst) trim_load |=> trim_reg == $past(cmd_trim)
			&& cont_reg == ($past(sec_tick) ? $past(cont_reg) + 1'b1 : $past(cont_reg));
	endproperty
	a_trim: assert property (p_trim) else $error("trim load wrong"); // R08

	property p_write_cont;
		@(posedge clk_sys) disable iff (sys_rst) wr_cont |=> cont_reg == $past(data_reg);
	endproperty
	a_write_cont: assert property (p_write_cont) else $error("continuous write wrong"); // R03

	property p_write_pow;
		@(posedge clk_sys) disable iff (sys_rst) wr_pow |=> pow_reg == $past(data_reg) && trim_reg == $past(trim_reg);
	endproperty
	a_write_pow: assert property (p_write_pow) else $error("powered write wrong"); // R05

	property p_refuse;
		@(posedge clk_sys) disable iff (sys_rst) frame_end && blocked_reg |=> $stable(trim_reg);
	endproperty
	a_refuse: assert property (p_refuse) else $error("access while supply low"); // R09

	property p_read_quiet;
		@(posedge clk_sys) disable iff (sys_rst)
			frame_end && cmd_read && counter_access(cmd_reg) |=> $stable(trim_reg);
	endproperty
	a_read_quiet: assert property (p_read_quiet) else $error("read changed trim"); // R02

	// Checks on the link side
	property p_cmd_shift;
		@(posedge ser_clk) disable iff (!port_en) in_cmd |=> cmd_reg == {$past(cmd_reg[6:0]), $past(dq_in)};
	endproperty
	a_cmd_shift: assert property (p_cmd_shift) else $error("command bit not sampled"); // R13

	property p_snapshot;
		@(posedge ser_clk) disable iff (!port_en)
			cmd_last && nxt_read && cmd_shift_next[seconds_counter_pkg::SEL_POW_BIT]
			&& !cmd_shift_next[seconds_counter_pkg::SEL_CONT_BIT] |=> data_reg == $past(shadow_pow_reg);
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("snapshot not taken"); // R04

	property p_drive_fall;
		@(negedge ser_clk) disable iff (!port_en) in_data && cmd_read && !blocked_reg |=> dq_oe_reg;
	endproperty
	a_drive_fall: assert property (p_drive_fall) else $error("read bit not driven"); // R14

	property p_done_quiet;
		@(posedge ser_clk) disable iff (!port_en) in_done && $past(in_done) |-> !dq_oe_reg;
	endproperty
	a_done_quiet: assert property (p_done_quiet) else $error("line driven after transfer"); // R16

endmodule // serial_elapsed_seconds_counter

/* File: tb/serial_host_model.sv */
// Behavioural host for the three-wire serial port
`timescale 1ns/1ps

module serial_host_model (
	output logic      ser_clk,
	output logic      port_en,
	output logic      dq_in,
	input  wire logic dq_out,
	input  wire logic dq_oe
);
	logic host_oe;
	logic host_bit;
	logic float_bit;

	// Resolved line; undriven it wanders so a stale bit never passes
	assign dq_in = dq_oe ? dq_out : (host_oe ? host_bit : float_bit);

	initial begin
		ser_clk = 1'b0;
		// Deferred so the device sees a clean edge on its frame clear
		port_en <= 1'b0;
		host_oe = 1'b0;
		host_bit = 1'b0;
		float_bit = 1'b0;
	end

	always #37 float_bit = ~float_bit;

	// Command MSB first, then nd data clocks LSB first; clock idles low
	task automatic frame(input logic [7:0] cmd, input logic [31:0] wdata, input int nd, input logic may_drive,
		output logic [31:0] rdata, output logic oe_bad);
		logic rd;
		rd = cmd[0] && (cmd[7] != cmd[6]);
		rdata = 32'h0;
		oe_bad = 1'b0;
		#7 port_en = 1'b1;
		#250;
		for (int i = 0; i < 8 + nd; i++) begin
			host_oe = !(rd && i >= 8);
			host_bit = (i < 8) ? cmd[7 - i] : wdata[(i + 24) % 32];
			#80 ser_clk = 1'b1;
			if (i >= 8 && i < 40)
				rdata[i - 8] = dq_in;
			if (dq_oe && !(may_drive && rd && i >= 8 && i < 40))
				oe_bad = 1'b1;
			// Enable drops only while the clock is high
			if (i == 7 + nd) begin
				#40 port_en = 1'b0;
				#40 ser_clk = 1'b0;
			end else begin
				#80 ser_clk = 1'b0;
			end
		end
		host_oe = 1'b0;
		#300;
	endtask
endmodule // serial_host_model

/* File: tb/testbench.sv */
// Self-checking bench for the serial seconds counter
`timescale 1ns/1ps

module testbench;
	logic        clk_sys;
	logic        sys_rst;
	logic        osc_tick;
	logic        supply_low;
	logic        ser_clk;
	logic        port_en;
	logic        dq_in;
	logic        dq_out;
	logic        dq_oe;
	logic [2:0]  trim_value;
	logic [31:0] continuous_count;
	logic [31:0] powered_count;
	logic [31:0] rdata;
	logic        oe_bad;
	int          fail_count;
	int          checks_done;

	serial_elapsed_seconds_counter uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ser_clk(ser_clk), .port_en(port_en), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .osc_tick(osc_tick), .supply_low(supply_low),
		.trim_value(trim_value), .continuous_count(continuous_count), .powered_count(powered_count)
	);

	serial_host_model host (
		.ser_clk(ser_clk), .port_en(port_en), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe)
	);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Frame end effects land a few clocks after enable falls
	task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd, input int nd, input logic may);
		host.frame(cmd, wd, nd, may, rdata, oe_bad);
		repeat (12) @(posedge clk_sys);
		check("line drive", {31'h0, oe_bad}, 32'h0);
	endtask

	// One second tick, long enough for the synchroniser
	task automatic tick();
		@(posedge clk_sys) osc_tick <= 1'b1;
		repeat (3) @(posedge clk_sys);
		osc_tick <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask

	task automatic counts(input string t, input logic [31:0] c, input logic [31:0] p, input logic [2:0] tr);
		check("continuous", continuous_count, c);
		check("powered", powered_count, p);
		check("trim", {29'h0, trim_value}, {29'h0, tr});
		$display("test %s done", t);
	endtask

	initial begin
		#1000000;
		fail_count++;
		$display("[FAIL] watchdog expected finish seen hang");
		give_verdict();
	end

	initial begin
		fail_count = 0;
		checks_done = 0;
		// Deferred so the link side flops already wait for the reset edge
		sys_rst <= 1'b1;
		osc_tick = 1'b0;
		supply_low = 1'b0;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		counts("reset", 32'h0, 32'h0, seconds_counter_pkg::TRIM_RESET);
		xfer(8'h80, 32'hA5C31E70, 32, 1'b1);
		counts("write continuous", 32'hA5C31E70, 32'h0, 3'h3);
		xfer(8'h40, 32'h12345678, 36, 1'b1);
		counts("write powered", 32'hA5C31E70, 32'h12345678, 3'h3);
		xfer(8'h80, 32'hFFFF0000, 16, 1'b1);
		counts("short write", 32'hA5C31E70, 32'h12345678, 3'h3);
		xfer(8'h81, 32'h0, 34, 1'b1);
		check("read continuous", rdata, 32'hA5C31E70);
		xfer(8'h41, 32'h0, 32, 1'b1);
		check("read powered", rdata, 32'h12345678);
		counts("reads", 32'hA5C31E70, 32'h12345678, 3'h3);
		// Tick lands mid-read; the snapshot must not move
		fork
			xfer(8'h81, 32'h0, 32, 1'b1);
			begin
				#3000;
				tick();
			end
		join
		check("snapshot", rdata, 32'hA5C31E70);
		counts("snapshot", 32'hA5C31E71, 32'h12345679, 3'h3);
		xfer(8'hE8, 32'h0, 0, 1'b1);
		counts("trim load", 32'hA5C31E71, 32'h12345679, 3'h5);
		xfer(8'hE9, 32'h0, 0, 1'b1);
		counts("trim with read", 32'hA5C31E71, 32'h12345679, 3'h5);
		xfer(8'h04, 32'h0, 0, 1'b1);
		counts("clear continuous", 32'h0, 32'h12345679, 3'h5);
		xfer(8'h02, 32'h0, 0, 1'b1);
		counts("clear powered", 32'h0, 32'h0, 3'h5);
		// Low supply: port refused and powered counter halts
		@(posedge clk_sys) supply_low <= 1'b1;
		repeat (12) @(posedge clk_sys);
		tick();
		xfer(8'h80, 32'hDEADBEEF, 32, 1'b1);
		xfer(8'h81, 32'h0, 32, 1'b0);
		xfer(8'h04, 32'h0, 0, 1'b1);
		xfer(8'hF8, 32'h0, 0, 1'b1);
		counts("supply low", 32'h1, 32'h0, 3'h5);
		@(posedge clk_sys) supply_low <= 1'b0;
		repeat (12) @(posedge clk_sys);
		xfer(8'hC0, 32'h0, 0, 1'b1);
		tick();
		counts("trim stop", 32'h1, 32'h0, seconds_counter_pkg::TRIM_STOP);
		give_verdict();
	end
endmodule // testbench
